// *** rtl/sdc_params.svh ***
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

`define SDC_CLK_PERIOD_NS 10

// Off time per off-time select level
`define SDC_OFF_TIME_SELECT_LOW_US   20
`define SDC_OFF_TIME_SELECT_HIGH_US  30
`define SDC_OFF_TIME_SELECT_FLOAT_US 10
`define SDC_OFF_TIME_SELECT_LOW_CYC   (`SDC_OFF_TIME_SELECT_LOW_US * 1000 / `SDC_CLK_PERIOD_NS)
`define SDC_OFF_TIME_SELECT_HIGH_CYC  (`SDC_OFF_TIME_SELECT_HIGH_US * 1000 / `SDC_CLK_PERIOD_NS)
`define SDC_OFF_TIME_SELECT_FLOAT_CYC (`SDC_OFF_TIME_SELECT_FLOAT_US * 1000 / `SDC_CLK_PERIOD_NS)

// Blanking intervals, least times rounded up to whole cycles
`define SDC_BLANK_180_NS 1800
`define SDC_BLANK_150_NS 1500
`define SDC_BLANK_120_NS 1200
`define SDC_BLANK_090_NS 900
`define SDC_BLANK_180_CYC ((`SDC_BLANK_180_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)
`define SDC_BLANK_150_CYC ((`SDC_BLANK_150_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)
`define SDC_BLANK_120_CYC ((`SDC_BLANK_120_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)
`define SDC_BLANK_090_CYC ((`SDC_BLANK_090_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)

// Sine code boundaries of the blanking table
`define SDC_CODE_9 5'h09
`define SDC_CODE_5 5'h05
`define SDC_CODE_3 5'h03

// Three-level pin codes
`define SDC_TRI_LOW   2'h0
`define SDC_TRI_HIGH  2'h1
`define SDC_TRI_FLOAT 2'h2

// Fast-decay shares in percent
`define SDC_PCT_FULL  7'h64
`define SDC_PCT_30    7'h1E
`define SDC_PCT_60    7'h3C
`define SDC_PCT_RESET 7'h1E

`endif

// *** rtl/sdc_pkg.sv ***
package sdc_pkg;

    typedef enum logic [1:0] {
        SDC_IDLE  = 2'b00,
        SDC_DRIVE = 2'b01,
        SDC_FAST  = 2'b11,
        SDC_SLOW  = 2'b10
    } sdc_state_t;

    typedef enum logic [2:0] {
        SDC_DEC_SLOW = 3'h0,
        SDC_DEC_M30  = 3'h1,
        SDC_DEC_M60  = 3'h2,
        SDC_DEC_M1B  = 3'h3,
        SDC_DEC_M2B  = 3'h4,
        SDC_DEC_FAST = 3'h5
    } sdc_decay_t;

endpackage : sdc_pkg

// *** rtl/sdc_blank_timer.sv ***
`timescale 1ns/1ns
`include "sdc_params.svh"

module sdc_blank_timer
    import sdc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       restart,
    input  wire logic [4:0] sineCode,
    input  wire logic [1:0] torque,
    output logic      [7:0] blankLength,
    output logic            blankDone
);

    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] next_blankLength;
    logic       next_blankDone;
    logic [7:0] lookup;

    always_comb begin
        lookup = 8'(`SDC_BLANK_090_CYC);
        unique case (torque)  // see [RL10] see [RL11]
            2'h0: begin
                if (sineCode >= `SDC_CODE_9)      lookup = 8'(`SDC_BLANK_180_CYC);
                else if (sineCode >= `SDC_CODE_5) lookup = 8'(`SDC_BLANK_150_CYC);
                else if (sineCode >= `SDC_CODE_3) lookup = 8'(`SDC_BLANK_120_CYC);
            end
            2'h1: begin
                if (sineCode >= `SDC_CODE_5)      lookup = 8'(`SDC_BLANK_150_CYC);
                else if (sineCode >= `SDC_CODE_3) lookup = 8'(`SDC_BLANK_120_CYC);
            end
            2'h2: begin
                if (sineCode >= `SDC_CODE_9)      lookup = 8'(`SDC_BLANK_150_CYC);
                else if (sineCode >= `SDC_CODE_5) lookup = 8'(`SDC_BLANK_120_CYC);
            end
            2'h3: begin
                if (sineCode >= `SDC_CODE_9)      lookup = 8'(`SDC_BLANK_120_CYC);
            end
        endcase
        next_blankLength = restart ? lookup : blankLength;
        next_count       = restart ? 8'h00 : (blankDone ? count : count + 8'h01);
        next_blankDone   = !restart && (blankDone || (count + 8'h01 >= blankLength));
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            count       <= 8'h00;
            blankLength <= 8'(`SDC_BLANK_090_CYC);
            blankDone   <= 1'b0;
        end else begin
            count       <= next_count;
            blankLength <= next_blankLength;
            blankDone   <= next_blankDone;
        end
    end

    a_blank_full_torque: assert property (@(posedge core_clk) disable iff (!resetn)
        restart && torque == 2'h0 && sineCode >= `SDC_CODE_9
        |=> blankLength == 8'(`SDC_BLANK_180_CYC))  // see [RL10]
        else $error("blanking length wrong at full torque high code");

    a_blank_quarter_low: assert property (@(posedge core_clk) disable iff (!resetn)
        restart && torque == 2'h3 && sineCode < `SDC_CODE_9
        |=> blankLength == 8'(`SDC_BLANK_090_CYC))  // see [RL11]
        else $error("blanking length wrong at quarter torque low code");

endmodule : sdc_blank_timer

// *** rtl/stepper_decay_chopper_control.sv ***
// Behaviour
// [RL1] Fast decay reverses bridge, off near zero
// [RL2] Slow/fast setting: fast only on falling steps
// [RL3] Host sets tuning high, decay pins low
// [RL4] Tuning latched only at wake or power-up
// [RL5] Tuning: overshoot raises fast share next cycle
// [RL6] Tuning: long drive lowers fast share
// [RL7] Tuning: falling steps use full fast decay
// [RL8] Sense ignored during blanking after drive start
// [RL9] Drive phase never shorter than blanking
// [RL10] Blanking table at 100% and 75% torque
// [RL11] Blanking table at 50% and 25% torque
// [RL12] Supply undervoltage: bridge, pump off, fault low
// [RL13] Supply undervoltage keeps logic and position
// [RL14] Logic undervoltage resets logic, regulator off
// [RL15] Fault stays low through logic undervoltage
// [RL16] Five selects three-level, others two-level
// [RL17] Decay pin pairs map to rise/fall modes
// [RL18] Tuning high overrides decay select pins
// [RL19] Full step always uses rising-step mode
// [RL20] Step direction from new versus previous code
`timescale 1ns/1ns
`include "sdc_params.svh"

module stepper_decay_chopper_control
    import sdc_pkg::*;
#(
    parameter int         POS_W         = 8,
    parameter logic [6:0] PCT_STEP      = 7'h05,
    parameter int         LONG_DRIVE    = 500,
    parameter logic [3:0] FULL_STEP_SEL = 4'h0
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             logicUndervoltage,
    input  wire logic             motorSupplyUndervoltage,
    input  wire logic             sleepRequestN,
    input  wire logic             enableIn,
    input  wire logic             tuningEnablePin,
    input  wire logic             torqueScaleBit0,
    input  wire logic             torqueScaleBit1,
    input  wire logic [1:0]       decaySelectLow,
    input  wire logic [1:0]       decaySelectHigh,
    input  wire logic [1:0]       offTimeSelect,
    input  wire logic [1:0]       stepModeSelect0,
    input  wire logic [1:0]       stepModeSelect1,
    input  wire logic             currentSenseInput,
    input  wire logic             zeroCurrent,
    input  wire logic             stepPulse,
    input  wire logic             stepDir,
    input  wire logic [4:0]       targetCode,
    input  wire logic             targetStrobe,
    output logic                  driveFwd,
    output logic                  driveRev,
    output logic                  lowSidesOn,
    output logic                  chargePumpEn,
    output logic                  auxRegulatorOutput,
    output logic                  faultOutN,
    output logic                  tuningLatched,
    output logic [6:0]            fastPercent,
    output logic [POS_W-1:0]      indexerPosition
);

    // Pins are asynchronous; all but the step and target inputs pass two flops before use
    localparam int SW = 19;
    logic [SW-1:0] syncA;
    logic [SW-1:0] syncB;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {logicUndervoltage, motorSupplyUndervoltage, sleepRequestN, enableIn,
                      tuningEnablePin, torqueScaleBit1, torqueScaleBit0, decaySelectHigh,
                      decaySelectLow, offTimeSelect, stepModeSelect1, stepModeSelect0,
                      currentSenseInput, zeroCurrent};
            syncB <= syncA;
        end
    end

    logic       luv, muv, awake, enSync, tuneSync, senseSync, zeroSync;
    logic [1:0] torque, decHi, decLo, offSel, m1, m0;
    assign {luv, muv, awake, enSync, tuneSync, torque, decHi, decLo, offSel, m1, m0,
            senseSync, zeroSync} = syncB;  // see [RL16]

    // Logic undervoltage clears all internal state except the pin synchronizers, like a power-up
    logic clr;
    assign clr = !resetn || luv;  // see [RL14]

    sdc_state_t      state, next_state;
    logic [11:0]     timer, next_timer;
    logic [11:0]     fastLen, next_fastLen;
    logic            zeroHit, next_zeroHit;
    logic            settled, next_settled;
    logic [4:0]      curCode, next_curCode;
    logic            falling, next_falling;
    logic            started, next_started;
    logic            awakePrev, next_awakePrev;
    logic            next_tuningLatched;
    logic [6:0]      next_fastPercent;
    logic [POS_W-1:0] next_indexerPosition;
    logic            next_driveFwd, next_driveRev, next_lowSidesOn;
    logic            next_chargePumpEn, next_aux, next_faultOutN;
    logic            restart, driveEnd, run, fullStep, useRise;
    logic [11:0]     offCycles, fastCycles;
    logic [6:0]      pctSel;
    sdc_decay_t      riseMode, fallMode, mode;
    logic [7:0]      blankLength;
    logic            blankDone;

    sdc_blank_timer u_blank (
        .core_clk    (core_clk),
        .resetn      (!clr),
        .restart     (restart),
        .sineCode    (curCode),
        .torque      (torque),
        .blankLength (blankLength),
        .blankDone   (blankDone)
    );

    // Decay mode table and per-cycle fast share
    always_comb begin
        riseMode = SDC_DEC_SLOW;
        fallMode = SDC_DEC_SLOW;
        unique case ({decHi, decLo})  // see [RL17]
            {`SDC_TRI_LOW,   `SDC_TRI_HIGH}:  fallMode = SDC_DEC_M2B;
            {`SDC_TRI_HIGH,  `SDC_TRI_LOW}:   fallMode = SDC_DEC_M30;
            {`SDC_TRI_HIGH,  `SDC_TRI_HIGH}: begin
                riseMode = SDC_DEC_M30;
                fallMode = SDC_DEC_M30;
            end
            {`SDC_TRI_LOW,   `SDC_TRI_FLOAT}: fallMode = SDC_DEC_M60;
            {`SDC_TRI_HIGH,  `SDC_TRI_FLOAT}: fallMode = SDC_DEC_FAST;  // see [RL2]
            {`SDC_TRI_FLOAT, `SDC_TRI_LOW}: begin
                riseMode = SDC_DEC_M1B;
                fallMode = SDC_DEC_M30;
            end
            {`SDC_TRI_FLOAT, `SDC_TRI_HIGH}: begin
                riseMode = SDC_DEC_M60;
                fallMode = SDC_DEC_M60;
            end
            {`SDC_TRI_FLOAT, `SDC_TRI_FLOAT}: begin
                riseMode = SDC_DEC_FAST;
                fallMode = SDC_DEC_FAST;
            end
            default: ;
        endcase
        fullStep = {m1, m0} == FULL_STEP_SEL;
        useRise  = fullStep || !falling;  // see [RL19]
        mode     = useRise ? riseMode : fallMode;
        unique case (offSel)
            `SDC_TRI_HIGH:  offCycles = 12'(`SDC_OFF_TIME_SELECT_HIGH_CYC);
            `SDC_TRI_FLOAT: offCycles = 12'(`SDC_OFF_TIME_SELECT_FLOAT_CYC);
            default:        offCycles = 12'(`SDC_OFF_TIME_SELECT_LOW_CYC);
        endcase
        pctSel = 7'h00;
        if (tuningLatched) begin  // see [RL18]
            pctSel = useRise ? fastPercent : `SDC_PCT_FULL;  // see [RL7]
        end else begin
            unique case (mode)
                SDC_DEC_M30:  pctSel = `SDC_PCT_30;
                SDC_DEC_M60:  pctSel = `SDC_PCT_60;
                SDC_DEC_FAST: pctSel = `SDC_PCT_FULL;
                default:      pctSel = 7'h00;
            endcase
        end
        fastCycles = 12'((20'(offCycles) * 20'(pctSel)) / 20'd100);
        if (!tuningLatched && mode == SDC_DEC_M1B) fastCycles = 12'(blankLength);
        if (!tuningLatched && mode == SDC_DEC_M2B) fastCycles = 12'({blankLength, 1'b0});
    end

    // Chopping sequence, tuning, indexer and supply handling
    always_comb begin
        run                  = awake && !muv && enSync && started;
        next_state           = state;
        next_timer           = (timer == 12'hFFF) ? timer : timer + 12'h001;
        next_fastLen         = fastLen;
        next_zeroHit         = zeroHit;
        next_settled         = settled;
        restart              = 1'b0;
        driveEnd             = 1'b0;
        if (!run) begin
            next_state = SDC_IDLE;
        end else begin
            unique case (state)
                SDC_IDLE: begin
                    next_state = SDC_DRIVE;
                    next_timer = 12'h000;
                    restart    = 1'b1;
                end
                SDC_DRIVE: begin
                    // Sense is acted on only once blanking has run out
                    next_settled = settled || (blankDone && !senseSync);
                    if (blankDone && senseSync) begin  // see [RL8] see [RL9]
                        driveEnd     = 1'b1;
                        next_state   = (fastCycles != 12'h000) ? SDC_FAST : SDC_SLOW;
                        next_timer   = 12'h000;
                        next_fastLen = fastCycles;
                        next_zeroHit = 1'b0;
                        next_settled = 1'b0;
                    end
                end
                SDC_FAST: begin
                    if (zeroSync) next_zeroHit = 1'b1;  // see [RL1]
                    if (timer + 12'h001 >= offCycles) begin
                        next_state = SDC_DRIVE;
                        next_timer = 12'h000;
                        restart    = 1'b1;
                    end else if (timer + 12'h001 >= fastLen) begin
                        next_state = SDC_SLOW;
                    end
                end
                SDC_SLOW: begin
                    if (timer + 12'h001 >= offCycles) begin
                        next_state = SDC_DRIVE;
                        next_timer = 12'h000;
                        restart    = 1'b1;
                    end
                end
            endcase
        end
        next_fastPercent = fastPercent;
        if (tuningLatched && driveEnd) begin
            // Trip on the first eligible sample means the current overshot
            if (!settled) begin  // see [RL5]
                next_fastPercent = (fastPercent + PCT_STEP > `SDC_PCT_FULL) ?
                                   `SDC_PCT_FULL : fastPercent + PCT_STEP;
            end else if (32'(timer) >= LONG_DRIVE) begin  // see [RL6]
                next_fastPercent = (fastPercent > PCT_STEP) ? fastPercent - PCT_STEP : 7'h00;
            end
        end
        next_curCode = targetStrobe ? targetCode : curCode;
        next_falling = targetStrobe ? (targetCode < curCode) : falling;  // see [RL20]
        next_started   = 1'b1;
        next_awakePrev = awake;
        // Mode pin is taken only at power-up or on leaving sleep
        next_tuningLatched = (!started || (awake && !awakePrev)) ? tuneSync
                                                                  : tuningLatched;  // see [RL4]
        // Indexer keeps counting through supply undervoltage
        next_indexerPosition = indexerPosition;
        if (stepPulse && awake) begin  // see [RL13]
            next_indexerPosition = stepDir ? indexerPosition + 1'b1 : indexerPosition - 1'b1;
        end
        next_driveFwd     = next_state == SDC_DRIVE;
        next_driveRev     = next_state == SDC_FAST && !next_zeroHit;  // see [RL1]
        next_lowSidesOn   = next_state == SDC_SLOW;
        next_chargePumpEn = awake && !muv;  // see [RL12]
        next_aux          = awake;
        // Fault is released one cycle after the pump is running again
        next_faultOutN    = !muv && chargePumpEn;  // see [RL12]
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            state              <= SDC_IDLE;
            timer              <= 12'h000;
            fastLen            <= 12'h000;
            zeroHit            <= 1'b0;
            settled            <= 1'b0;
            curCode            <= 5'h01;
            falling            <= 1'b0;
            started            <= 1'b0;
            awakePrev          <= 1'b0;
            tuningLatched      <= 1'b0;
            fastPercent        <= `SDC_PCT_RESET;
            indexerPosition    <= '0;  // see [RL14]
            driveFwd           <= 1'b0;
            driveRev           <= 1'b0;
            lowSidesOn         <= 1'b0;
            chargePumpEn       <= 1'b0;
            auxRegulatorOutput <= 1'b0;  // see [RL14]
            faultOutN          <= 1'b0;  // see [RL15]
        end else begin
            state              <= next_state;
            timer              <= next_timer;
            fastLen            <= next_fastLen;
            zeroHit            <= next_zeroHit;
            settled            <= next_settled;
            curCode            <= next_curCode;
            falling            <= next_falling;
            started            <= next_started;
            awakePrev          <= next_awakePrev;
            tuningLatched      <= next_tuningLatched;
            fastPercent        <= next_fastPercent;
            indexerPosition    <= next_indexerPosition;
            driveFwd           <= next_driveFwd;
            driveRev           <= next_driveRev;
            lowSidesOn         <= next_lowSidesOn;
            chargePumpEn       <= next_chargePumpEn;
            auxRegulatorOutput <= next_aux;
            faultOutN          <= next_faultOutN;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_fast_reverse: assert property (state == SDC_FAST && !zeroHit |-> driveRev && !driveFwd) // see [RL1]
        else $error("fast decay without reversed drive");
    a_zero_cutoff: assert property (state == SDC_FAST && zeroHit |-> !driveRev && !driveFwd) // see [RL1]
        else $error("bridge still on after zero current");
    a_slow_rising: assert property (!tuningLatched && {decHi, decLo} == {`SDC_TRI_HIGH,
        `SDC_TRI_FLOAT} && useRise |-> fastCycles == 12'h000) // see [RL2]
        else $error("fast decay on rising step in slow/fast setting");
    a_tune_hold: assert property (started && !(awake && !awakePrev) && !luv
        |=> $stable(tuningLatched)) // see [RL4]
        else $error("tuning mode changed outside wake");
    a_tune_up: assert property (tuningLatched && driveEnd && !settled && !luv
        && fastPercent < `SDC_PCT_FULL |=> fastPercent > $past(fastPercent)) // see [RL5]
        else $error("overshoot did not raise fast share");
    a_tune_down: assert property (tuningLatched && driveEnd && settled && !luv
        && 32'(timer) >= LONG_DRIVE && fastPercent != 7'h00
        |=> fastPercent < $past(fastPercent)) // see [RL6]
        else $error("long drive did not lower fast share");
    a_fall_fast: assert property (tuningLatched && falling && !fullStep
        |-> fastCycles == offCycles) // see [RL7]
        else $error("falling step not in fast decay");
    a_blank_ignore: assert property (state == SDC_DRIVE && !blankDone && run && !luv
        |=> state == SDC_DRIVE) // see [RL8]
        else $error("drive left during blanking");
    a_min_drive: assert property (state == SDC_DRIVE && next_state != SDC_DRIVE && run
        |-> timer + 12'h001 >= 12'(blankLength)) // see [RL9]
        else $error("drive phase shorter than blanking");
    a_uv_outputs: assert property (muv && !luv |=> !chargePumpEn && !faultOutN
        && !driveFwd && !driveRev && !lowSidesOn) // see [RL12]
        else $error("supply undervoltage left bridge or pump on");
    a_fault_release: assert property ($rose(faultOutN) |-> $past(chargePumpEn, 1)) // see [RL12]
        else $error("fault released before resuming");
    a_uv_position: assert property (muv && !luv && !stepPulse
        |=> $stable(indexerPosition) || $past(luv)) // see [RL13]
        else $error("position lost during supply undervoltage");
    a_luv_reset: assert property (luv |=> indexerPosition == '0 && !auxRegulatorOutput
        && !faultOutN) // see [RL14] see [RL15]
        else $error("logic undervoltage did not reset");

    c_fast_phase: cover property (state == SDC_DRIVE ##1 state == SDC_FAST);
    c_tune_raise: cover property (tuningLatched && driveEnd && !settled);
    c_uv_recover: cover property (muv ##1 !muv [*3] ##1 faultOutN);
    c_zero_cut:   cover property (state == SDC_FAST && zeroHit);

endmodule : stepper_decay_chopper_control

// *** tb/sdc_winding_model.sv ***
`timescale 1ns/1ns

module sdc_winding_model (
    input  wire logic        core_clk,
    input  wire logic        driveFwd,
    input  wire logic        driveRev,
    input  wire logic        lowSidesOn,
    input  wire logic        alwaysTrip,
    input  wire logic [15:0] tripLevel,
    output logic             currentSenseInput,
    output logic             zeroCurrent
);
    int level = 0;

    // Reversed bridge drains fast, recirculation slowly
    always @(posedge core_clk) begin
        if (driveFwd)
            level <= level + 1;
        else if (driveRev)
            level <= (level > 4) ? level - 4 : 0;
        else if (lowSidesOn && level > 0)
            level <= level - 1;
    end

    // Forced trip models a winding that overshoots at once
    assign currentSenseInput = alwaysTrip || (level >= int'(tripLevel));
    assign zeroCurrent       = (level < 4);
endmodule : sdc_winding_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns

module tb_top;
    import sdc_pkg::*;
    typedef struct {logic [1:0] trq; logic [4:0] code; int blank;} sdc_row_t;
    logic core_clk = 0, resetn = 0, luv = 0, muv = 0, sleepN = 1, enable = 1;
    logic tunePin = 0, torque_scale_bit0 = 0, torque_scale_bit1 = 0, step = 0, dir = 1, strobe = 0, trip = 1;
    logic [1:0] decLow = 2'h0, decHigh = 2'h0, offSel = 2'h2, mode0 = 2'h1, mode1 = 2'h0;
    logic [4:0] code = 5'h10;
    logic [15:0] tripLevel = 16'h0190;
    logic fwd, rev, lowOn, pumpEn, auxOn, faultN, tuned, sense, zero;
    logic [6:0] fastPct;
    logic [7:0] pos;
    int err_total = 0, checks_done = 0, dur;
    sdc_row_t rows[12] = '{'{2'h0, 5'h09, 180}, '{2'h0, 5'h08, 150}, '{2'h0, 5'h04, 120},
        '{2'h0, 5'h02, 90}, '{2'h1, 5'h05, 150}, '{2'h1, 5'h03, 120}, '{2'h1, 5'h01, 90},
        '{2'h2, 5'h09, 150}, '{2'h2, 5'h05, 120}, '{2'h2, 5'h04, 90}, '{2'h3, 5'h09, 120},
        '{2'h3, 5'h08, 90}};

    always #5 core_clk = ~core_clk;

    stepper_decay_chopper_control #(.LONG_DRIVE(300)) uut (.core_clk(core_clk),
        .resetn(resetn), .logicUndervoltage(luv), .motorSupplyUndervoltage(muv),
        .sleepRequestN(sleepN), .enableIn(enable), .tuningEnablePin(tunePin),
        .torqueScaleBit0(torque_scale_bit0), .torqueScaleBit1(torque_scale_bit1), .decaySelectLow(decLow),
        .decaySelectHigh(decHigh), .offTimeSelect(offSel), .stepModeSelect0(mode0),
        .stepModeSelect1(mode1), .currentSenseInput(sense), .zeroCurrent(zero),
        .stepPulse(step), .stepDir(dir), .targetCode(code), .targetStrobe(strobe),
        .driveFwd(fwd), .driveRev(rev), .lowSidesOn(lowOn), .chargePumpEn(pumpEn),
        .auxRegulatorOutput(auxOn), .faultOutN(faultN), .tuningLatched(tuned),
        .fastPercent(fastPct), .indexerPosition(pos));

    sdc_winding_model winding (.core_clk(core_clk), .driveFwd(fwd), .driveRev(rev),
        .lowSidesOn(lowOn), .alwaysTrip(trip), .tripLevel(tripLevel),
        .currentSenseInput(sense), .zeroCurrent(zero));

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("Mismatches %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // Waits for a fresh drive phase and measures its length
    task automatic pwm();
        while (fwd !== 1'b0) cyc(1);
        while (fwd !== 1'b1) cyc(1);
        for (dur = 0; fwd === 1'b1; dur++) cyc(1);
    endtask : pwm

    task automatic pulse(logic d);
        dir = d;
        step = 1;
        cyc(1);
        step = 0;
        cyc(1);
    endtask : pulse

    initial begin
        cyc(5);
        check("fault_in_reset", faultN, 8'h00);
        resetn = 1;
        cyc(8);
        check("pump_up", pumpEn, 8'h01);
        check("fault_up", faultN, 8'h01);
        foreach (rows[i]) begin
            {torque_scale_bit1, torque_scale_bit0} = rows[i].trq;
            code = rows[i].code;
            strobe = 1;
            cyc(1);
            strobe = 0;
            cyc(4);
            pwm();
            check("drive_len", 8'(dur >= rows[i].blank && dur <= rows[i].blank + 5), 8'h01);
        end
        muv = 1;
        pulse(1);
        pulse(1);
        pulse(1);
        pulse(0);
        check("muv_bridge", {pumpEn, faultN, fwd, rev, lowOn}, 8'h00);
        check("muv_pos", pos, 8'h02);
        muv = 0;
        cyc(8);
        check("muv_back", {pumpEn, faultN}, 8'h03);
        muv = 1;
        luv = 1;
        cyc(5);
        check("luv_pos", pos, 8'h00);
        check("luv_out", {auxOn, faultN}, 8'h00);
        luv = 0;
        muv = 0;
        enable = 0;
        // Recovery from logic undervoltage is a power-up and latches the pin
        cyc(8);
        tunePin = 1;
        cyc(8);
        check("tune_held", tuned, 8'h00);
        sleepN = 0;
        cyc(6);
        sleepN = 1;
        cyc(8);
        check("tune_wake", tuned, 8'h01);
        enable = 1;
        pwm();
        cyc(3);
        check("tune_up", fastPct, 8'h23);
        check("fast_rev", {fwd, rev}, 8'h01);
        trip = 0;
        cyc(80);
        check("fast_off", {fwd, rev}, 8'h00);
        pwm();
        cyc(3);
        check("tune_down", fastPct, 8'h1E);
        stop_test();
    end

    initial begin
        #400000;
        err_total++;
        stop_test();
    end
endmodule : tb_top
